// >>> logic/sbp_pkg.sv
// Shared constants and types
package sbp_pkg;
    // Sizes
    localparam int SBP_NUM    = 4;
    localparam int SBP_IW     = 2;
    localparam int SBP_BUF_W  = SBP_IW + 8;
    localparam int SBP_BUF_D  = 4;

    // Register selects
    localparam logic [2:0] SBP_SEL_INDEX  = 3'h0;
    localparam logic [2:0] SBP_SEL_CONFIG = 3'h1;
    localparam logic [2:0] SBP_SEL_MASK   = 3'h2;
    localparam logic [2:0] SBP_SEL_ASSIGN = 3'h3;
    localparam logic [2:0] SBP_SEL_MODE   = 3'h4;

    // Index select direction bit
    localparam int SBP_IDX_DIR_BIT = 7;

    // subchannel_config layout
    localparam int SBP_CFG_CNT_LSB   = 0;
    localparam int SBP_CFG_START_LSB = 3;
    localparam int SBP_CFG_HDLC_BIT  = 6;
    localparam int SBP_CFG_EN_BIT    = 7;

    // Reset values
    localparam logic [7:0] SBP_CFG_RESET  = 8'h00;
    localparam logic [7:0] SBP_MASK_RESET = 8'h00;

    // Data flow modes
    localparam logic [1:0] SBP_SIMPLE_MODE         = 2'h0;
    localparam logic [1:0] SBP_CHANNEL_SELECT_MODE = 2'h1;
    localparam logic [1:0] SBP_FIFO_SEQUENCE_MODE  = 2'h2;

    localparam logic [3:0] SBP_BYTE_BITS = 4'h8;

    // Frame timing
    localparam int SBP_FRAME_NS     = 125000;
    localparam int SBP_CLK_NS       = 8;
    localparam int SBP_FRAME_CYCLES = SBP_FRAME_NS / SBP_CLK_NS;

    typedef enum logic {SBP_IDLE, SBP_RUN} sbp_seq_type;
endpackage

// >>> logic/sbp_link_if.sv
// Link between the two ends
interface sbp_link_if;
    import sbp_pkg::*;
    logic                              frame_tick;
    logic                              cfg_we;
    logic [2:0]                        cfg_sel;
    logic [7:0]                        cfg_wdata;
    logic [SBP_NUM-1:0][7:0]           line_rx_byte;
    logic [SBP_NUM-1:0][7:0]           hdlc_tx_bits;
    logic [SBP_NUM-1:0]                hdlc_tx_take;
    logic [SBP_NUM-1:0][3:0]           hdlc_tx_cnt;
    logic [SBP_NUM-1:0]                hdlc_rx_valid;
    logic [SBP_NUM-1:0][7:0]           hdlc_rx_bits;
    logic [SBP_NUM-1:0][3:0]           hdlc_rx_cnt;
    logic                              line_tx_valid;
    logic                              line_tx_ready;
    logic [SBP_IW-1:0]                 line_tx_ch;
    logic [7:0]                        line_tx_byte;

    modport dev (
        input  frame_tick, cfg_we, cfg_sel, cfg_wdata, line_rx_byte, hdlc_tx_bits,
        input  line_tx_ready,
        output hdlc_tx_take, hdlc_tx_cnt, hdlc_rx_valid, hdlc_rx_bits, hdlc_rx_cnt,
        output line_tx_valid, line_tx_ch, line_tx_byte
    );
    modport host (
        output frame_tick, cfg_we, cfg_sel, cfg_wdata, line_rx_byte, hdlc_tx_bits,
        output line_tx_ready,
        input  hdlc_tx_take, hdlc_tx_cnt, hdlc_rx_valid, hdlc_rx_bits, hdlc_rx_cnt,
        input  line_tx_valid, line_tx_ch, line_tx_byte
    );
endinterface

// >>> logic/sbp_device.sv
// Subchannel processor end and its line buffer
module sbp_buf #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        do_wr;
    logic                        do_rd;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            mem    <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// Functional notes
// - Transparent TX: byte field to start position
// - FIFO-side field always aligned to bit 0
// - Start position 0..7 per FIFO configuration
// - Channel mask used on transmit only
// - Processed bits stored back into mask
// - Mask per channel, selected by index
// - Reset configuration gives transparent whole bytes; the reset value 8'h00 leaves the enable bit clear, so no FIFO is connected
// - Byte per frame transparent, bit_count HDLC
// - One byte each direction per frame
// - HDLC TX requests bit_count, zero means eight
// - Transparent RX shifts down, upper bits kept
// - Software sets count zero, upper bits kept
// - HDLC RX forwards only bit_count field bits
// - Line side: one byte per frame
// - Simple mode: FIFO number equals channel
// - Insert field into mask before sending
// - Select/sequence modes merge all connected FIFOs
// - Sharing FIFOs should use distinct bit locations
// - Simple-mode RX byte to the FIFO of the same number
// - Select/sequence RX byte to every assigner
// - Processing only on paths through a FIFO
module sbp_device
    import sbp_pkg::*;
#(
    parameter int BUF_DEPTH = SBP_BUF_D
) (
    // Clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  reset_n_i,
    // Link
    sbp_link_if.dev    link,
    // Status
    output logic       busy_o,
    output logic [1:0] mode_o
);
    import sbp_pkg::*;

    typedef struct packed {
        sbp_seq_type                   seq;
        logic [SBP_IW-1:0]             ch;
        logic [7:0]                    index;
        logic [1:0]                    mode;
        logic [SBP_NUM-1:0][7:0]       cfg_tx;
        logic [SBP_NUM-1:0][7:0]       cfg_rx;
        logic [SBP_NUM-1:0][SBP_IW-1:0] chan;
        logic [SBP_NUM-1:0][7:0]       mask;
        logic [SBP_NUM-1:0]            take;
        logic [SBP_NUM-1:0][3:0]       take_cnt;
        logic [SBP_NUM-1:0]            rx_valid;
        logic [SBP_NUM-1:0][7:0]       rx_bits;
        logic [SBP_NUM-1:0][3:0]       rx_cnt;
    } sbp_dev_state_type;

    sbp_dev_state_type s;
    sbp_dev_state_type next_s;
    logic [7:0]        tx_byte;
    logic              buf_in_ready;
    logic [SBP_BUF_W-1:0] buf_out;

    // Zero count means a whole byte
    function automatic logic [3:0] sbp_width(input logic [7:0] cfg);
        logic [2:0] cnt;
        cnt = cfg[SBP_CFG_CNT_LSB +: 3];
        return (cnt == 3'h0) ? SBP_BYTE_BITS : {1'b0, cnt};
    endfunction

    // Low-aligned field mask
    function automatic logic [7:0] sbp_low_mask(input logic [7:0] cfg);
        return 8'hFF >> (SBP_BYTE_BITS - sbp_width(cfg));
    endfunction

    // Field mask at start position
    function automatic logic [7:0] sbp_field_mask(input logic [7:0] cfg);
        logic [15:0] wide;
        wide = {8'h00, sbp_low_mask(cfg)} << cfg[SBP_CFG_START_LSB +: 3];
        return wide[7:0];
    endfunction

    // Channel that FIFO f talks to
    function automatic logic [SBP_IW-1:0] sbp_chan_of(input sbp_dev_state_type st,
                                                      input int f);
        return (st.mode == SBP_SIMPLE_MODE) ? SBP_IW'(f) : st.chan[f];
    endfunction

    always_comb begin
        logic [15:0] placed;
        logic [7:0]  fm;
        logic [7:0]  rx_byte;
        logic [7:0]  shifted;
        placed  = '0;
        fm      = '0;
        rx_byte = '0;
        shifted = '0;
        next_s  = s;
        next_s.take     = '0;
        next_s.rx_valid = '0;

        // Stored mask, then every connected field
        tx_byte = s.mask[s.ch];
        for (int f = 0; f < SBP_NUM; f++) begin
            if (s.cfg_tx[f][SBP_CFG_EN_BIT] && sbp_chan_of(s, f) == s.ch) begin
                fm      = sbp_field_mask(s.cfg_tx[f]);
                placed  = {8'h00, link.hdlc_tx_bits[f]} << s.cfg_tx[f][SBP_CFG_START_LSB +: 3];
                tx_byte = (tx_byte & ~fm) | (placed[7:0] & fm);
            end
        end

        case (s.seq)
            SBP_IDLE: begin
                // Frames arriving mid-sweep are dropped; the sweep is short
                if (link.frame_tick) begin
                    for (int f = 0; f < SBP_NUM; f++) begin
                        if (s.cfg_rx[f][SBP_CFG_EN_BIT]) begin
                            rx_byte = link.line_rx_byte[sbp_chan_of(s, f)];
                            shifted = rx_byte >> s.cfg_rx[f][SBP_CFG_START_LSB +: 3];
                            next_s.rx_valid[f] = 1'b1;
                            if (s.cfg_rx[f][SBP_CFG_HDLC_BIT]) begin
                                next_s.rx_bits[f] = shifted & sbp_low_mask(s.cfg_rx[f]);
                                next_s.rx_cnt[f]  = sbp_width(s.cfg_rx[f]);
                            end else begin
                                next_s.rx_bits[f] = shifted;
                                next_s.rx_cnt[f]  = SBP_BYTE_BITS;
                            end
                        end
                    end
                    next_s.seq = SBP_RUN;
                    next_s.ch  = '0;
                end
            end
            SBP_RUN: begin
                // Full buffer stalls the sweep
                if (buf_in_ready) begin
                    next_s.mask[s.ch] = tx_byte;
                    for (int f = 0; f < SBP_NUM; f++) begin
                        if (s.cfg_tx[f][SBP_CFG_EN_BIT] && sbp_chan_of(s, f) == s.ch) begin
                            next_s.take[f] = 1'b1;
                            next_s.take_cnt[f] = s.cfg_tx[f][SBP_CFG_HDLC_BIT] ?
                                                 sbp_width(s.cfg_tx[f]) : SBP_BYTE_BITS;
                        end
                    end
                    if (s.ch == SBP_IW'(SBP_NUM-1)) begin
                        next_s.seq = SBP_IDLE;
                    end else begin
                        next_s.ch = s.ch + 1'b1;
                    end
                end
            end
            default: begin
                next_s.seq = SBP_IDLE;
            end
        endcase

        // Software writes win over store-back
        if (link.cfg_we) begin
            case (link.cfg_sel)
                SBP_SEL_INDEX: begin
                    next_s.index = link.cfg_wdata;
                end
                SBP_SEL_CONFIG: begin
                    if (s.index[SBP_IDX_DIR_BIT]) begin
                        next_s.cfg_rx[s.index[SBP_IW-1:0]] = link.cfg_wdata;
                    end else begin
                        next_s.cfg_tx[s.index[SBP_IW-1:0]] = link.cfg_wdata;
                    end
                end
                SBP_SEL_MASK: begin
                    // Receive-channel index has no mask
                    if (!s.index[SBP_IDX_DIR_BIT]) begin
                        next_s.mask[s.index[SBP_IW-1:0]] = link.cfg_wdata;
                    end
                end
                SBP_SEL_ASSIGN: begin
                    next_s.chan[s.index[SBP_IW-1:0]] = link.cfg_wdata[SBP_IW-1:0];
                end
                SBP_SEL_MODE: begin
                    next_s.mode = link.cfg_wdata[1:0];
                end
                default: begin
                    next_s.mode = s.mode;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            s        <= '0;
            s.seq    <= SBP_IDLE;
            s.mode   <= SBP_SIMPLE_MODE;
            s.cfg_tx <= {SBP_NUM{SBP_CFG_RESET}};
            s.cfg_rx <= {SBP_NUM{SBP_CFG_RESET}};
            s.mask   <= {SBP_NUM{SBP_MASK_RESET}};
        end else begin
            s <= next_s;
        end
    end

    sbp_buf #(
        .WIDTH (SBP_BUF_W),
        .DEPTH (BUF_DEPTH)
    ) u_line_buf (
        .sys_clk_i   (sys_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (s.seq == SBP_RUN),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({s.ch, tx_byte}),
        .out_valid_o (link.line_tx_valid),
        .out_ready_i (link.line_tx_ready),
        .out_data_o  (buf_out)
    );

    assign link.line_tx_ch   = buf_out[SBP_BUF_W-1 -: SBP_IW];
    assign link.line_tx_byte = buf_out[7:0];
    assign link.hdlc_tx_take = s.take;
    assign link.hdlc_tx_cnt  = s.take_cnt;
    assign link.hdlc_rx_valid = s.rx_valid;
    assign link.hdlc_rx_bits = s.rx_bits;
    assign link.hdlc_rx_cnt  = s.rx_cnt;
    assign busy_o            = (s.seq == SBP_RUN);
    assign mode_o            = s.mode;
endmodule

// >>> logic/sbp_host.sv
// Controller and line end
module sbp_host
    import sbp_pkg::*;
#(
    parameter int FRAME_CYCLES = SBP_FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic                          sys_clk_i,
    input  wire logic                          reset_n_i,
    // Link
    sbp_link_if.host                           link,
    // Configuration commands
    input  wire logic                          user_cfg_we_i,
    input  wire logic [2:0]                    user_cfg_sel_i,
    input  wire logic [7:0]                    user_cfg_wdata_i,
    input  wire logic                          user_mask_we_i,
    input  wire logic [SBP_IW-1:0]             user_mask_ch_i,
    input  wire logic [7:0]                    user_mask_i,
    output logic                               user_cmd_busy_o,
    output logic                               user_mask_stale_o,
    // Transmit FIFO bytes
    input  wire logic                          user_tx_we_i,
    input  wire logic [SBP_IW-1:0]             user_tx_fifo_i,
    input  wire logic [7:0]                    user_tx_byte_i,
    output logic [SBP_NUM-1:0]                 user_tx_taken_o,
    // Receive FIFO fields
    output logic [SBP_NUM-1:0]                 user_rx_valid_o,
    output logic [SBP_NUM-1:0][7:0]            user_rx_bits_o,
    output logic [SBP_NUM-1:0][3:0]            user_rx_cnt_o,
    // Line channels
    input  wire logic [SBP_NUM-1:0][7:0]       user_line_rx_i,
    input  wire logic                          user_line_ready_i,
    output logic                               user_line_valid_o,
    output logic [SBP_IW-1:0]                  user_line_ch_o,
    output logic [7:0]                         user_line_byte_o
);
    import sbp_pkg::*;

    localparam int FCW = $clog2(FRAME_CYCLES + 1);

    typedef struct packed {
        logic [FCW-1:0]           frame_cnt;
        logic                     tick;
        logic                     cfg_we;
        logic [2:0]               cfg_sel;
        logic [7:0]               cfg_wdata;
        logic                     rx_dir;
        logic [1:0]               mask_stage;
        logic [SBP_IW-1:0]        mask_ch;
        logic [7:0]               mask_val;
        logic                     stale;
        logic [SBP_NUM-1:0][7:0]  line_rx;
        logic [SBP_NUM-1:0][7:0]  tx_hold;
        logic [SBP_NUM-1:0]       taken;
        logic [SBP_NUM-1:0]       rx_valid;
        logic [SBP_NUM-1:0][7:0]  rx_bits;
        logic [SBP_NUM-1:0][3:0]  rx_cnt;
        logic                     out_valid;
        logic [SBP_IW-1:0]        out_ch;
        logic [7:0]               out_byte;
    } sbp_host_state_type;

    sbp_host_state_type h;
    sbp_host_state_type next_h;
    logic               line_ready;

    assign line_ready = !h.out_valid || user_line_ready_i;

    always_comb begin
        next_h = h;
        next_h.cfg_we = 1'b0;
        next_h.tick   = 1'b0;

        if (h.frame_cnt == FCW'(FRAME_CYCLES - 1)) begin
            next_h.frame_cnt = '0;
            next_h.tick      = 1'b1;
        end else begin
            next_h.frame_cnt = h.frame_cnt + 1'b1;
        end

        // Mask write: index, then value
        case (h.mask_stage)
            2'h1: begin
                next_h.cfg_we     = 1'b1;
                next_h.cfg_sel    = SBP_SEL_INDEX;
                next_h.cfg_wdata  = {1'b0, 7'(h.mask_ch)};
                next_h.rx_dir     = 1'b0;
                next_h.mask_stage = 2'h2;
            end
            2'h2: begin
                next_h.cfg_we     = 1'b1;
                next_h.cfg_sel    = SBP_SEL_MASK;
                next_h.cfg_wdata  = h.mask_val;
                next_h.stale      = 1'b0;
                next_h.mask_stage = 2'h0;
            end
            default: begin
                if (user_mask_we_i) begin
                    next_h.mask_ch    = user_mask_ch_i;
                    next_h.mask_val   = user_mask_i;
                    next_h.mask_stage = 2'h1;
                end else if (user_cfg_we_i) begin
                    next_h.cfg_we    = 1'b1;
                    next_h.cfg_sel   = user_cfg_sel_i;
                    next_h.cfg_wdata = user_cfg_wdata_i;
                    if (user_cfg_sel_i == SBP_SEL_INDEX) begin
                        next_h.rx_dir = user_cfg_wdata_i[SBP_IDX_DIR_BIT];
                    end
                    if (user_cfg_sel_i == SBP_SEL_CONFIG) begin
                        // Stored mask holds old fields until rewritten
                        next_h.stale = 1'b1;
                        if (h.rx_dir && !user_cfg_wdata_i[SBP_CFG_HDLC_BIT]) begin
                            next_h.cfg_wdata[SBP_CFG_CNT_LSB +: 3] = 3'h0;
                        end
                    end
                end
            end
        endcase

        if (user_tx_we_i) begin
            next_h.tx_hold[user_tx_fifo_i] = user_tx_byte_i;
        end
        next_h.taken = link.hdlc_tx_take;

        // Line bytes only via the processor
        next_h.line_rx = user_line_rx_i;
        next_h.rx_valid = link.hdlc_rx_valid;
        for (int f = 0; f < SBP_NUM; f++) begin
            if (link.hdlc_rx_valid[f]) begin
                next_h.rx_bits[f] = link.hdlc_rx_bits[f];
                next_h.rx_cnt[f]  = link.hdlc_rx_cnt[f];
            end
        end

        if (line_ready) begin
            next_h.out_valid = link.line_tx_valid;
            if (link.line_tx_valid) begin
                next_h.out_ch   = link.line_tx_ch;
                next_h.out_byte = link.line_tx_byte;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            h <= '0;
        end else begin
            h <= next_h;
        end
    end

    assign link.frame_tick    = h.tick;
    assign link.cfg_we        = h.cfg_we;
    assign link.cfg_sel       = h.cfg_sel;
    assign link.cfg_wdata     = h.cfg_wdata;
    assign link.line_rx_byte  = h.line_rx;
    assign link.hdlc_tx_bits  = h.tx_hold;
    assign link.line_tx_ready = line_ready;
    assign user_cmd_busy_o    = (h.mask_stage != 2'h0);
    assign user_mask_stale_o  = h.stale;
    assign user_tx_taken_o    = h.taken;
    assign user_rx_valid_o    = h.rx_valid;
    assign user_rx_bits_o     = h.rx_bits;
    assign user_rx_cnt_o      = h.rx_cnt;
    assign user_line_valid_o  = h.out_valid;
    assign user_line_ch_o     = h.out_ch;
    assign user_line_byte_o   = h.out_byte;
endmodule

// >>> bench/sbp_link_sva.sv
// Link assertions
module sbp_link_sva
    import sbp_pkg::*;
(
    // Clock and reset
    input wire logic                    sys_clk_i,
    input wire logic                    reset_n_i,
    // Link signals
    input wire logic                    frame_tick,
    input wire logic [SBP_NUM-1:0]      hdlc_tx_take,
    input wire logic [SBP_NUM-1:0][3:0] hdlc_tx_cnt,
    input wire logic [SBP_NUM-1:0]      hdlc_rx_valid,
    input wire logic [SBP_NUM-1:0][7:0] hdlc_rx_bits,
    input wire logic [SBP_NUM-1:0][3:0] hdlc_rx_cnt,
    input wire logic                    line_tx_valid,
    input wire logic                    line_tx_ready,
    input wire logic [SBP_IW-1:0]       line_tx_ch,
    input wire logic [7:0]              line_tx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    property p_take_cnt;
        hdlc_tx_take[0] |-> hdlc_tx_cnt[0] inside {[4'h1:4'h8]};
    endproperty
    a_take_cnt: assert property (p_take_cnt) else $error("take count out of range");
    property p_take_once;
        hdlc_tx_take[0] |=> !hdlc_tx_take[0] [*8];
    endproperty
    a_take_once: assert property (p_take_once) else $error("second take in one frame");
    property p_rx_tick;
        hdlc_rx_valid != 4'h0 |-> $past(frame_tick);
    endproperty
    a_rx_tick: assert property (p_rx_tick) else $error("field without frame");
    property p_rx_once;
        hdlc_rx_valid[0] |=> !hdlc_rx_valid[0] [*8];
    endproperty
    a_rx_once: assert property (p_rx_once) else $error("second field in one frame");
    property p_rx_field;
        hdlc_rx_valid[0] && hdlc_rx_cnt[0] < 4'h8 |-> (hdlc_rx_bits[0] >> hdlc_rx_cnt[0]) == 8'h00;
    endproperty
    a_rx_field: assert property (p_rx_field) else $error("bits above field count");
    property p_rx_cnt;
        hdlc_rx_valid[0] |-> hdlc_rx_cnt[0] inside {[4'h1:4'h8]};
    endproperty
    a_rx_cnt: assert property (p_rx_cnt) else $error("receive count out of range");
    property p_line_hold;
        line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_byte) && $stable(line_tx_ch);
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("line byte dropped");
    property p_tick_push;
        frame_tick |-> ##[1:6] line_tx_valid;
    endproperty
    a_tick_push: assert property (p_tick_push) else $error("no line byte after frame");
    property p_ch_order;
        line_tx_valid && line_tx_ready ##1 line_tx_valid |-> line_tx_ch == $past(line_tx_ch) + 2'h1;
    endproperty
    a_ch_order: assert property (p_ch_order) else $error("line channel out of order");
    c_frame: cover property (frame_tick);
    c_hdlc_rx: cover property (hdlc_rx_valid[2] && hdlc_rx_cnt[2] == 4'h3);
    c_stall: cover property (line_tx_valid && !line_tx_ready);
endmodule

// >>> bench/subchannel_bit_processor_bench.sv
// Self-checking bench for both ends
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module subchannel_bit_processor_bench
    import sbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FR = 16;
    logic                    sys_clk_i = 1'b0;
    logic                    reset_n_i = 1'b0;
    logic                    cfg_we = 1'b0, mask_we = 1'b0, tx_we = 1'b0, line_ready = 1'b1;
    logic [2:0]              cfg_sel = 3'h0;
    logic [7:0]              cfg_data = 8'h00, mask = 8'h00, tx_byte = 8'h00, line_byte;
    logic [SBP_IW-1:0]       mask_ch = 2'h0, tx_fifo = 2'h0, line_ch;
    logic [SBP_NUM-1:0][7:0] line_rx = '0, rx_bits;
    logic [SBP_NUM-1:0][3:0] rx_cnt;
    logic [SBP_NUM-1:0]      rx_valid, seen_tx = '0, seen_rx = '0;
    logic                    line_valid;
    logic [1:0]              mode;
    logic [7:0]              got_tx [SBP_NUM];
    logic [11:0]             got_rx [SBP_NUM];
    int                      bad_count = 0, tests_run = 0;
    sbp_link_if sbp_link_if_i ();
    sbp_device sbp_device_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .link(sbp_link_if_i), .busy_o(), .mode_o(mode));
    sbp_host #(.FRAME_CYCLES(FR)) sbp_host_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .link(sbp_link_if_i), .user_cfg_we_i(cfg_we), .user_cfg_sel_i(cfg_sel),
        .user_cfg_wdata_i(cfg_data), .user_mask_we_i(mask_we), .user_mask_ch_i(mask_ch),
        .user_mask_i(mask), .user_cmd_busy_o(), .user_mask_stale_o(), .user_tx_we_i(tx_we),
        .user_tx_fifo_i(tx_fifo), .user_tx_byte_i(tx_byte), .user_tx_taken_o(),
        .user_rx_valid_o(rx_valid), .user_rx_bits_o(rx_bits), .user_rx_cnt_o(rx_cnt),
        .user_line_rx_i(line_rx), .user_line_ready_i(line_ready),
        .user_line_valid_o(line_valid), .user_line_ch_o(line_ch), .user_line_byte_o(line_byte));
    sbp_link_sva sbp_link_sva_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .frame_tick(sbp_link_if_i.frame_tick), .hdlc_tx_take(sbp_link_if_i.hdlc_tx_take),
        .hdlc_tx_cnt(sbp_link_if_i.hdlc_tx_cnt), .hdlc_rx_valid(sbp_link_if_i.hdlc_rx_valid),
        .hdlc_rx_bits(sbp_link_if_i.hdlc_rx_bits), .hdlc_rx_cnt(sbp_link_if_i.hdlc_rx_cnt),
        .line_tx_valid(sbp_link_if_i.line_tx_valid), .line_tx_ready(sbp_link_if_i.line_tx_ready),
        .line_tx_ch(sbp_link_if_i.line_tx_ch), .line_tx_byte(sbp_link_if_i.line_tx_byte));
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // First byte of a window only
    always @(posedge sys_clk_i) begin
        if (line_valid && line_ready && !seen_tx[line_ch]) begin
            got_tx[line_ch] <= line_byte;
            seen_tx[line_ch] <= 1'b1;
        end
        for (int f = 0; f < SBP_NUM; f++) begin
            if (rx_valid[f] && !seen_rx[f]) begin
                got_rx[f] <= {rx_cnt[f], rx_bits[f]};
                seen_rx[f] <= 1'b1;
            end
        end
    end
    task automatic cmd(input logic [2:0] sel, input logic [7:0] data);
        @(posedge sys_clk_i);
        cfg_we <= 1'b1;
        cfg_sel <= sel;
        cfg_data <= data;
        @(posedge sys_clk_i);
        cfg_we <= 1'b0;
    endtask
    task automatic set_mask(input logic [1:0] ch, input logic [7:0] m);
        @(posedge sys_clk_i);
        mask_we <= 1'b1;
        mask_ch <= ch;
        mask <= m;
        @(posedge sys_clk_i);
        mask_we <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic load(input logic [1:0] f, input logic [7:0] b);
        @(posedge sys_clk_i);
        tx_we <= 1'b1;
        tx_fifo <= f;
        tx_byte <= b;
        @(posedge sys_clk_i);
        tx_we <= 1'b0;
    endtask
    // Drain bytes of older settings, then clear off the edge
    task automatic frames();
        repeat (FR) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        seen_tx = '0;
        seen_rx = '0;
        repeat (2 * FR) @(posedge sys_clk_i);
    endtask
    task automatic t_reset();
        `CHK(mode, SBP_SIMPLE_MODE)
        cmd(SBP_SEL_INDEX, 8'h00);
        cmd(SBP_SEL_CONFIG, 8'h80);
        cmd(SBP_SEL_INDEX, 8'h80);
        cmd(SBP_SEL_CONFIG, 8'h80);
        line_rx[0] <= 8'h3C;
        load(2'h0, 8'hA5);
        frames();
        `CHK(got_tx[0], 8'hA5)
        `CHK(got_rx[0], 12'h83C)
        $display("test reset done");
    endtask
    task automatic t_field();
        cmd(SBP_SEL_INDEX, 8'h01);
        cmd(SBP_SEL_CONFIG, 8'h8B);
        cmd(SBP_SEL_INDEX, 8'h81);
        cmd(SBP_SEL_CONFIG, 8'h88);
        set_mask(2'h1, 8'hB0);
        line_rx[1] <= 8'h5B;
        load(2'h1, 8'hFD);
        frames();
        `CHK(got_tx[1], 8'hBA)
        `CHK(got_rx[1], 12'h82D)
        cmd(SBP_SEL_INDEX, 8'h01);
        cmd(SBP_SEL_CONFIG, 8'hA3);
        frames();
        `CHK(got_tx[1], 8'hDA)
        set_mask(2'h1, 8'hB0);
        frames();
        `CHK(got_tx[1], 8'hD0)
        $display("test field done");
    endtask
    task automatic t_hdlc();
        cmd(SBP_SEL_INDEX, 8'h02);
        cmd(SBP_SEL_CONFIG, 8'hF3);
        cmd(SBP_SEL_INDEX, 8'h82);
        cmd(SBP_SEL_CONFIG, 8'hDB);
        set_mask(2'h2, 8'h00);
        line_rx[2] <= 8'h28;
        load(2'h2, 8'hFF);
        frames();
        `CHK(got_tx[2], 8'hC0)
        `CHK(got_rx[2], 12'h305)
        $display("test hdlc done");
    endtask
    task automatic t_stall();
        line_ready <= 1'b0;
        repeat (3 * FR) @(posedge sys_clk_i);
        `CHK(line_valid, 1'b1)
        line_ready <= 1'b1;
        frames();
        `CHK(got_tx[0], 8'hA5)
        $display("test stall done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_field();
        t_hdlc();
        t_stall();
        conclude();
    end
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        bad_count++;
        conclude();
    end
endmodule
